// file: rtl/epos_defs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef EPOS_DEFS_VH
`define EPOS_DEFS_VH

// Avalon word offsets (byte address = 4 * index)
`define EPOS_REG_CTRL1 4'h0
`define EPOS_REG_CTRL2 4'h1
`define EPOS_REG_CTRL3 4'h2
`define EPOS_REG_T2CTRL 4'h3
`define EPOS_REG_WDCTRL 4'h4
`define EPOS_REG_SHARED 4'h5
`define EPOS_REG_CFG 4'h6
`define EPOS_REG_PERIOD 4'h7
`define EPOS_REG_DUTY 4'h8
`define EPOS_REG_STATUS 4'h9

// Module, watchdog and timer 2 control fields
`define EPOS_OUTCFG_HI 7
`define EPOS_OUTCFG_LO 6
`define EPOS_MODE_HI 3
`define EPOS_MODE_LO 0
`define EPOS_DIR_BIT 7
`define EPOS_ADSEL_BIT 4
`define EPOS_PSC_HI 1
`define EPOS_PSC_LO 0

// Config bits in the configuration register
`define EPOS_CFG_M2REMAP 0
`define EPOS_CFG_BCREMAP 1
`define EPOS_CFG_EXTMEM 2
`define EPOS_CFG_EMBW_LO 3
`define EPOS_CFG_EMBW_HI 4

// Output configuration codes
`define EPOS_OC_SINGLE 2'h0
`define EPOS_OC_FULLFWD 2'h1
`define EPOS_OC_HALF 2'h2
`define EPOS_OC_FULLREV 2'h3

// Mode field and memory bus width codes
`define EPOS_MODE_OFF 4'h0
`define EPOS_MODE_PWM 4'hc
`define EPOS_EMB_12BIT 2'h1

// Reset values
`define EPOS_RST_CTRL 8'h00
`define EPOS_RST_CFG 8'h07
`define EPOS_RST_PERIOD 8'hff

// Direction-change lead in timer counts, each count one prescale span
`define EPOS_DIRCHG_TOSC 8'h04

`endif

// file: rtl/epos_prescale.v
// Timebase prescaler: tick every 1, 4 or 16 clocks
`timescale 1ns/1ps
module epos_prescale (
    input wire core_clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire [1:0] psc_sel_i,
    output reg tick_o
);
    reg [3:0] cnt;
    reg [3:0] lim;

    always @* begin
        if (psc_sel_i == 2'h0) begin
            lim = 4'h0;
        end else if (psc_sel_i == 2'h1) begin
            lim = 4'h3;
        end else begin
            lim = 4'hf;
        end
    end

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            cnt <= 4'h0;
            tick_o <= 1'b0;
        end else if (ce_i) begin
            if (cnt >= lim) begin
                cnt <= 4'h0;
                tick_o <= 1'b1;
            end else begin
                cnt <= cnt + 4'h1;
                tick_o <= 1'b0;
            end
        end
    end
endmodule

// file: rtl/epos_pwm_core.v
// Enhanced PWM output generator with full-bridge direction change
`timescale 1ns/1ps
`include "epos_defs.vh"
module epos_pwm_core (
    input wire core_clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire tick_i,
    input wire [7:0] period_i,
    input wire [7:0] duty_i,
    input wire [1:0] out_cfg_i,
    input wire [3:0] mode_i,
    output reg [3:0] abcd_o,
    output reg dir_o
);
    reg [7:0] tmr;
    reg pwm;
    reg blank;
    wire pwm_on = (mode_i[3:2] == 2'h3);
    wire full = out_cfg_i[0];
    wire want_rev = (out_cfg_i == `EPOS_OC_FULLREV);
    wire [7:0] lead_pt;

    // A count lasts one prescale span, so 4 counts are 4 Tosc times it
    // Periods under 4 counts start the lead at count zero
    assign lead_pt = (period_i < `EPOS_DIRCHG_TOSC) ? 8'h00 :
        period_i - `EPOS_DIRCHG_TOSC;

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            tmr <= 8'h00;
            pwm <= 1'b0;
            blank <= 1'b0;
            dir_o <= 1'b0;
            abcd_o <= 4'h0;
        end else if (ce_i) begin
            if (tick_i) begin
                if (tmr >= period_i) begin
                    tmr <= 8'h00;
                    pwm <= (duty_i != 8'h00);
                    blank <= 1'b0;
                end else begin
                    tmr <= tmr + 8'h01;
                    if (tmr + 8'h01 >= duty_i) begin
                        pwm <= 1'b0;
                    end
                end
                // Direction sampled once, 4 counts before the period ends
                if (full && tmr == lead_pt && want_rev != dir_o) begin
                    dir_o <= want_rev;
                    blank <= 1'b1;
                end
            end
            if (!pwm_on) begin
                abcd_o <= 4'h0;
            end else if (out_cfg_i == `EPOS_OC_SINGLE) begin
                abcd_o <= {3'h0, pwm};
            end else if (out_cfg_i == `EPOS_OC_HALF) begin
                abcd_o <= {2'h0, ~pwm, pwm};
            end else if (!dir_o) begin
                // No dead band in full bridge
                abcd_o <= {pwm & ~blank, 2'h0, 1'b1};
            end else begin
                abcd_o <= {1'b0, 1'b1, pwm & ~blank, 1'b0};
            end
        end
    end
endmodule

// file: rtl/epos_top.v
// Output steering, pin mux and register file of the enhanced PWM
`timescale 1ns/1ps
`include "epos_defs.vh"
// Summary of operation
// - Each module drives up to four outputs A to D, count set by mode.
// - Output configuration from control bits 7:6 and mode bits 3:0.
// - Extended memory bus overrides B and C of modules 1 and 3.
// - With 12-bit bus width, B and C stay available on port E.
// - Clearing the B/C remap bit moves B and C to port H.
// - Module 2 on port C bit 1 when remap set, else port E bit 7.
// - In extended memory mode the cleared remap uses port B bit 3.
// - Quad mode of module 1 or 3 takes pin of standard module 5 or 4.
// - Capture/compare use timer 1 or 3; PWM uses timer 2 or 4.
// - Open-drain bit makes the module pin driver open-drain, for modules 1 to 3 only in compare or single-output PWM modes.
// - Open-drain register shares timer 1 high byte, selected by bit 4.
// - Full-bridge direction write takes effect at next period.
// - Before change, B and D go inactive and A and C swap.
// - Lead prescale is 1, 4 or 16 from prescale bits 1:0.
// - Modulated outputs stay inactive until the next period.
// - No dead band in full-bridge mode.
module epos_top (
    input wire core_clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire std4_out_i,
    input wire std5_out_i,
    output reg [2:0] mod2_pin_o,
    output reg [7:0] bridge_pin_o,
    output reg [4:0] od_pin_o,
    output reg [3:0] timer_sel_o
);
    reg [7:0] module1_control_reg;
    reg [7:0] module2_control_reg;
    reg [7:0] module3_control_reg;
    reg [7:0] timer2_control_reg;
    reg [7:0] watchdog_control_reg;
    reg [7:0] open_drain_control_reg;
    reg [7:0] timer_one_high_byte;
    reg [7:0] cfg_reg;
    reg [7:0] period_reg;
    reg [7:0] duty_reg;
    reg done;
    reg [31:0] rd_word;
    wire tick;
    wire [3:0] m1_abcd;
    wire [3:0] m2_abcd;
    wire [3:0] m3_abcd;
    wire [2:0] dirs;
    wire module2_pin_remap_cfg = cfg_reg[`EPOS_CFG_M2REMAP];
    wire bridge_bc_pin_remap_cfg = cfg_reg[`EPOS_CFG_BCREMAP];
    wire ext_mem = cfg_reg[`EPOS_CFG_EXTMEM];
    wire [1:0] memory_bus_width_cfg =
        cfg_reg[`EPOS_CFG_EMBW_HI:`EPOS_CFG_EMBW_LO];
    wire sel_alt = watchdog_control_reg[`EPOS_ADSEL_BIT];
    wire acc = (avs_read | avs_write) & ~done;

    function is_pwm;
        input [7:0] ctl;
        begin
            is_pwm = (ctl[3:2] == 2'h3);
        end
    endfunction

    function is_quad;
        input [7:0] ctl;
        begin
            is_quad = is_pwm(ctl) & ctl[`EPOS_OUTCFG_LO];
        end
    endfunction

    function od_mode;
        input [7:0] ctl;
        begin
            od_mode = (ctl[3:2] == 2'h2) | (is_pwm(ctl) &
                (ctl[`EPOS_OUTCFG_HI:`EPOS_OUTCFG_LO] == `EPOS_OC_SINGLE));
        end
    endfunction

    // Open-drain only in compare or single-output PWM modes
    wire [2:0] od_ok = {od_mode(module3_control_reg),
        od_mode(module2_control_reg), od_mode(module1_control_reg)};
    wire [1:0] psc_sel = timer2_control_reg[`EPOS_PSC_HI:`EPOS_PSC_LO];

    epos_prescale u_psc (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .psc_sel_i(psc_sel),
        .tick_o(tick)
    );

    // One core per enhanced module, sharing the timebase
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_core
            wire [7:0] ctl = (g == 0) ? module1_control_reg :
                (g == 1) ? module2_control_reg : module3_control_reg;
            wire [3:0] outs;
            epos_pwm_core u_core (
                .core_clk_i(core_clk_i),
                .rst_i(rst_i),
                .ce_i(ce_i),
                .tick_i(tick),
                .period_i(period_reg),
                .duty_i(duty_reg),
                .out_cfg_i(ctl[`EPOS_OUTCFG_HI:`EPOS_OUTCFG_LO]),
                .mode_i(ctl[`EPOS_MODE_HI:`EPOS_MODE_LO]),
                .abcd_o(outs),
                .dir_o(dirs[g])
            );
        end
    endgenerate
    assign m1_abcd = g_core[0].outs;
    assign m2_abcd = g_core[1].outs;
    assign m3_abcd = g_core[2].outs;

    // Read mux; shared address picks alternate register
    always @* begin
        rd_word = 32'h0000_0000;
        if (avs_address == `EPOS_REG_CTRL1) begin
            rd_word[7:0] = module1_control_reg;
        end else if (avs_address == `EPOS_REG_CTRL2) begin
            rd_word[7:0] = module2_control_reg;
        end else if (avs_address == `EPOS_REG_CTRL3) begin
            rd_word[7:0] = module3_control_reg;
        end else if (avs_address == `EPOS_REG_T2CTRL) begin
            rd_word[7:0] = timer2_control_reg;
        end else if (avs_address == `EPOS_REG_WDCTRL) begin
            rd_word[7:0] = watchdog_control_reg;
        end else if (avs_address == `EPOS_REG_SHARED) begin
            rd_word[7:0] = sel_alt ? {3'h0, open_drain_control_reg[4:0]} :
                timer_one_high_byte;
        end else if (avs_address == `EPOS_REG_CFG) begin
            rd_word[7:0] = cfg_reg;
        end else if (avs_address == `EPOS_REG_PERIOD) begin
            rd_word[7:0] = period_reg;
        end else if (avs_address == `EPOS_REG_DUTY) begin
            rd_word[7:0] = duty_reg;
        end else if (avs_address == `EPOS_REG_STATUS) begin
            rd_word[2:0] = dirs;
        end
    end

    // One wait cycle per access, then answer
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            done <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            module1_control_reg <= `EPOS_RST_CTRL;
            module2_control_reg <= `EPOS_RST_CTRL;
            module3_control_reg <= `EPOS_RST_CTRL;
            timer2_control_reg <= `EPOS_RST_CTRL;
            watchdog_control_reg <= `EPOS_RST_CTRL;
            open_drain_control_reg <= `EPOS_RST_CTRL;
            timer_one_high_byte <= `EPOS_RST_CTRL;
            cfg_reg <= `EPOS_RST_CFG;
            period_reg <= `EPOS_RST_PERIOD;
            duty_reg <= `EPOS_RST_CTRL;
        end else if (ce_i) begin
            done <= acc;
            avs_waitrequest <= ~acc;
            if (acc && avs_read) begin
                avs_readdata <= rd_word;
            end
            if (acc && avs_write && avs_byteenable[0]) begin
                if (avs_address == `EPOS_REG_CTRL1) begin
                    module1_control_reg <= avs_writedata[7:0];
                end else if (avs_address == `EPOS_REG_CTRL2) begin
                    module2_control_reg <= avs_writedata[7:0];
                end else if (avs_address == `EPOS_REG_CTRL3) begin
                    module3_control_reg <= avs_writedata[7:0];
                end else if (avs_address == `EPOS_REG_T2CTRL) begin
                    timer2_control_reg <= avs_writedata[7:0];
                end else if (avs_address == `EPOS_REG_WDCTRL) begin
                    watchdog_control_reg <= avs_writedata[7:0];
                end else if (avs_address == `EPOS_REG_SHARED) begin
                    if (sel_alt) begin
                        open_drain_control_reg <= {3'h0,
                            avs_writedata[4:0]};
                    end else begin
                        timer_one_high_byte <= avs_writedata[7:0];
                    end
                end else if (avs_address == `EPOS_REG_CFG) begin
                    cfg_reg <= avs_writedata[7:0];
                end else if (avs_address == `EPOS_REG_PERIOD) begin
                    period_reg <= avs_writedata[7:0];
                end else if (avs_address == `EPOS_REG_DUTY) begin
                    duty_reg <= avs_writedata[7:0];
                end
            end
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // Pin steering
    reg bc_blocked;
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            mod2_pin_o <= 3'h0;
            bridge_pin_o <= 8'h00;
            od_pin_o <= 5'h00;
            timer_sel_o <= 4'h0;
            bc_blocked <= 1'b0;
        end else if (ce_i) begin
            // Bus on port E blocks B/C unless 12-bit width or moved to H
            bc_blocked <= ext_mem & bridge_bc_pin_remap_cfg &
                (memory_bus_width_cfg != `EPOS_EMB_12BIT);
            // Bit0 port C1, bit1 port E7, bit2 port B3
            if (module2_pin_remap_cfg) begin
                mod2_pin_o <= {2'h0, m2_abcd[0]};
            end else if (ext_mem) begin
                mod2_pin_o <= {m2_abcd[0], 2'h0};
            end else begin
                mod2_pin_o <= {1'b0, m2_abcd[0], 1'b0};
            end
            // Bits: 1A,1B,1C,1D(std5 pin),3A,3B,3C,3D(std4 pin)
            bridge_pin_o[0] <= m1_abcd[0];
            bridge_pin_o[1] <= m1_abcd[1] & ~bc_blocked;
            bridge_pin_o[2] <= m1_abcd[2] & ~bc_blocked;
            bridge_pin_o[3] <= is_quad(module1_control_reg) ?
                m1_abcd[3] : std5_out_i;
            bridge_pin_o[4] <= m3_abcd[0];
            bridge_pin_o[5] <= m3_abcd[1] & ~bc_blocked;
            bridge_pin_o[6] <= m3_abcd[2] & ~bc_blocked;
            bridge_pin_o[7] <= is_quad(module3_control_reg) ?
                m3_abcd[3] : std4_out_i;
            od_pin_o <= {open_drain_control_reg[4:3],
                open_drain_control_reg[2:0] & od_ok};
            // Per module: 1 = PWM timer (2/4), 0 = timer 1/3
            timer_sel_o <= {1'b0, is_pwm(module3_control_reg),
                is_pwm(module2_control_reg),
                is_pwm(module1_control_reg)};
        end
    end
endmodule

// file: tb/epos_switch_model.sv
// Full-bridge power switches that turn off slower than on
`timescale 1ns/1ps
module epos_switch_model #(
    parameter [3:0] TOFF = 4'h2
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire [3:0] gate_i,
    output reg [7:0] shoot_cnt_o
);
    reg [3:0] lag [0:3];
    reg [3:0] on;
    integer i, j;
    always @* begin
        for (i = 0; i < 4; i = i + 1)
            on[i] = gate_i[i] || lag[i] != 4'h0;
    end
    // Legs are A/B and C/D; both conducting is shoot-through
    always @(posedge core_clk_i) begin
        for (j = 0; j < 4; j = j + 1) begin
            if (rst_i || gate_i[j])
                lag[j] <= rst_i ? 4'h0 : TOFF;
            else if (lag[j] != 4'h0)
                lag[j] <= lag[j] - 4'h1;
        end
        if (rst_i)
            shoot_cnt_o <= 8'h00;
        else if ((on[0] && on[1]) || (on[2] && on[3]))
            shoot_cnt_o <= shoot_cnt_o + 8'h01;
    end
endmodule

// file: tb/epos_top_props.sv
// Port assertions for the PWM output steering block
`timescale 1ns/1ps
module epos_top_props (
    input wire core_clk_i,
    input wire rst_i,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire [2:0] mod2_pin_o,
    input wire [7:0] bridge_pin_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // Module 1 unmodulated drive moving from A to C
    sequence s_swap;
        $rose(bridge_pin_o[2]) && $past(bridge_pin_o[0]);
    endsequence
    chk_answer_next: assert property ($rose(avs_read || avs_write)
        |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not one cycle after request");
    chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_unmapped_zero: assert property (avs_read && !avs_waitrequest
        && avs_address > 4'h9 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    chk_reset_clear: assert property ($past(rst_i) |-> bridge_pin_o == 8'h0
        && mod2_pin_o == 3'h0 && avs_waitrequest)
        else $error("outputs not cleared by reset");
    chk_swap_no_gap: assert property (s_swap |-> !bridge_pin_o[0]
        && !bridge_pin_o[1] && !bridge_pin_o[3])
        else $error("direction swap not clean");
    chk_mod_hold: assert property (s_swap |=>
        (!bridge_pin_o[1] && !bridge_pin_o[3]) [*3])
        else $error("modulated output active after swap");
    chk_ac_apart: assert property (!(bridge_pin_o[0] && bridge_pin_o[2])
        && !(bridge_pin_o[4] && bridge_pin_o[6]))
        else $error("both unmodulated outputs driven");
    chk_mod2_one_pin: assert property ($onehot0(mod2_pin_o))
        else $error("module 2 output on several pins");
    cover property (s_swap);
    cover property (mod2_pin_o[2]);
    cover property (avs_read && !avs_waitrequest);
endmodule
bind epos_top epos_top_props u_props (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mod2_pin_o(mod2_pin_o),
    .bridge_pin_o(bridge_pin_o));

// file: tb/tb_enhanced_pwm_output_steering.sv
// Self-checking bench for the PWM output steering block
`timescale 1ns/1ps
`include "epos_defs.vh"
module tb_enhanced_pwm_output_steering;
    reg core_clk_i = 1'b0, rst_i = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    reg std5_out_i = 1'b0, std4_out_i = 1'b0, ce_i = 1'b1;
    reg [3:0] avs_address = 4'h0;
    reg [31:0] avs_writedata = 32'h0;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire [2:0] mod2_pin_o;
    wire [7:0] bridge_pin_o, shoot_cnt;
    wire [4:0] od_pin_o;
    wire [3:0] timer_sel_o;
    integer err_total = 0, cmp_count = 0;
    reg [7:0] q, hi, lo, shoot0;
    reg [2:0] m2;
    always #50 core_clk_i = ~core_clk_i;
    epos_top u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .std4_out_i(std4_out_i),
        .std5_out_i(std5_out_i), .mod2_pin_o(mod2_pin_o),
        .bridge_pin_o(bridge_pin_o), .od_pin_o(od_pin_o),
        .timer_sel_o(timer_sel_o));
    epos_switch_model u_sw (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .gate_i(bridge_pin_o[3:0]), .shoot_cnt_o(shoot_cnt));
    task final_report;
        begin
            $display("compares %0d mismatches %0d", cmp_count, err_total);
            if (err_total == 0 && cmp_count > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task chk(input string what, input [7:0] exp, input [7:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("unexpected %0s: expected %h seen %h",
                    what, exp, got);
            end
        end
    endtask
    // Request held until waitrequest is sampled low
    task bus(input w, input [3:0] a, input [7:0] d);
        integer n;
        begin
            @(posedge core_clk_i);
            avs_address <= a;
            avs_write <= w;
            avs_read <= !w;
            avs_writedata <= {24'h0, d};
            n = 0;
            do begin
                @(posedge core_clk_i);
                n = n + 1;
            end while (avs_waitrequest !== 1'b0 && n < 64);
            q = avs_readdata[7:0];
            if (n >= 64)
                err_total = err_total + 1;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask
    // Settle, then gather which pins were ever high or low
    task watch;
        integer i;
        begin
            hi = 8'h0;
            lo = 8'h0;
            m2 = 3'h0;
            repeat (4) @(negedge core_clk_i);
            for (i = 0; i < 300; i = i + 1) begin
                @(negedge core_clk_i);
                hi = hi | bridge_pin_o;
                lo = lo | ~bridge_pin_o;
                m2 = m2 | mod2_pin_o;
            end
        end
    endtask
    task t_regs;
        begin
            bus(1'b0, `EPOS_REG_CFG, 8'h0);
            chk("cfg reset", `EPOS_RST_CFG, q);
            bus(1'b0, `EPOS_REG_PERIOD, 8'h0);
            chk("period reset", `EPOS_RST_PERIOD, q);
            bus(1'b0, `EPOS_REG_CTRL1, 8'h0);
            chk("ctrl1 reset", `EPOS_RST_CTRL, q);
            bus(1'b1, 4'hf, 8'h5a);
            bus(1'b0, 4'hf, 8'h0);
            chk("unmapped", 8'h00, q);
            bus(1'b1, `EPOS_REG_PERIOD, 8'h3f);
            bus(1'b1, `EPOS_REG_DUTY, 8'h20);
        end
    endtask
    task t_timer_od;
        begin
            bus(1'b1, `EPOS_REG_CTRL1, 8'h0c);
            bus(1'b1, `EPOS_REG_CTRL2, 8'h08);
            bus(1'b1, `EPOS_REG_CTRL3, 8'h0c);
            repeat (4) @(negedge core_clk_i);
            chk("timer select", 8'h05, {5'h0, timer_sel_o[2:0]});
            bus(1'b1, `EPOS_REG_WDCTRL, 8'h00);
            bus(1'b1, `EPOS_REG_SHARED, 8'h1f);
            repeat (4) @(negedge core_clk_i);
            chk("od unselected", 8'h00, {5'h0, od_pin_o[2:0]});
            bus(1'b1, `EPOS_REG_WDCTRL, 8'h10);
            bus(1'b0, `EPOS_REG_SHARED, 8'h0);
            chk("od read", 8'h00, q);
            bus(1'b1, `EPOS_REG_SHARED, 8'h07);
            repeat (4) @(negedge core_clk_i);
            chk("od enable", 8'h07, {5'h0, od_pin_o[2:0]});
            bus(1'b1, `EPOS_REG_CTRL1, 8'h4c);
            repeat (4) @(negedge core_clk_i);
            chk("od full bridge", 8'h06, {5'h0, od_pin_o[2:0]});
        end
    endtask
    task m2_case(input [7:0] cfg, input [2:0] exp);
        begin
            bus(1'b1, `EPOS_REG_CFG, cfg);
            watch;
            chk("mod2 pin", {5'h0, exp}, {5'h0, m2});
        end
    endtask
    task bc_case(input [7:0] cfg, input [1:0] exp);
        begin
            bus(1'b1, `EPOS_REG_CFG, cfg);
            watch;
            chk("b outputs", {6'h0, exp}, {6'h0, hi[5], hi[1]});
        end
    endtask
    task t_quad;
        begin
            @(posedge core_clk_i);
            std5_out_i <= 1'b1;
            std4_out_i <= 1'b1;
            bus(1'b1, `EPOS_REG_CTRL1, 8'h0c);
            watch;
            chk("std passthru", 8'h00, {6'h0, lo[7], lo[3]});
            chk("single b c", 8'h00, {6'h0, hi[2:1]});
            bus(1'b1, `EPOS_REG_CTRL1, 8'h4c);
            bus(1'b1, `EPOS_REG_CTRL3, 8'h4c);
            watch;
            chk("quad d", 8'h03, {6'h0, lo[7], lo[3]});
            @(posedge core_clk_i);
            std5_out_i <= 1'b0;
            std4_out_i <= 1'b0;
        end
    endtask
    // Clock enable low must hold every bridge pin still
    task t_freeze;
        begin
            @(posedge core_clk_i);
            ce_i <= 1'b0;
            @(negedge core_clk_i);
            hi = bridge_pin_o;
            lo = 8'h00;
            repeat (80) begin
                @(negedge core_clk_i);
                lo = lo | (hi ^ bridge_pin_o);
            end
            chk("frozen pins", 8'h00, lo);
            @(posedge core_clk_i);
            ce_i <= 1'b1;
        end
    endtask
    // Reverse written just after a period starts; lead measured C to B
    task t_dir(input [1:0] psc, input [7:0] lead);
        integer n;
        begin
            bus(1'b1, `EPOS_REG_T2CTRL, {6'h0, psc});
            bus(1'b1, `EPOS_REG_CTRL1, 8'h4c);
            shoot0 = shoot_cnt;
            n = 0;
            do @(negedge core_clk_i); while (bridge_pin_o[3] !== 1'b0);
            do begin
                @(negedge core_clk_i);
                n = n + 1;
            end while (bridge_pin_o[3] !== 1'b1 && n < 5000);
            bus(1'b1, `EPOS_REG_CTRL1, 8'hcc);
            @(negedge core_clk_i);
            chk("forward kept", 8'h01, {7'h0, bridge_pin_o[0]});
            n = 0;
            do begin
                @(negedge core_clk_i);
                n = n + 1;
            end while (bridge_pin_o[2] !== 1'b1 && n < 5000);
            q = {6'h0, bridge_pin_o[3], bridge_pin_o[1]};
            chk("b d at swap", 8'h00, q);
            n = 0;
            do begin
                @(negedge core_clk_i);
                n = n + 1;
            end while (bridge_pin_o[1] !== 1'b1 && n < 200);
            chk("swap lead", lead, n[7:0]);
            chk("shoot count", shoot0, shoot_cnt);
        end
    endtask
    initial begin
        #4000000;
        err_total = err_total + 1;
        final_report;
    end
    initial begin
        repeat (16) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_timer_od;
        bus(1'b1, `EPOS_REG_CTRL2, 8'h0c);
        m2_case(8'h07, 3'b001);
        m2_case(8'h02, 3'b010);
        m2_case(8'h06, 3'b100);
        bus(1'b1, `EPOS_REG_CTRL1, 8'h8c);
        bus(1'b1, `EPOS_REG_CTRL3, 8'h8c);
        bc_case(8'h07, 2'b00);
        bc_case(8'h0f, 2'b11);
        bc_case(8'h05, 2'b11);
        t_quad;
        t_freeze;
        t_dir(2'h0, 8'd4);
        t_dir(2'h1, 8'd16);
        t_dir(2'h2, 8'd64);
        final_report;
    end
endmodule
